// file: txph_top.v
// transmit packet handler, fifo, apb registers and symbol mapper
`timescale 1ns/1ps
`default_nettype none
`include "txph_consts.vh"

module txph_top #(
   parameter DEPTH_LOG2 = 6,
   parameter FIFO_THR = 33
) (
   // clock and reset
   input wire clk,
   input wire srst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // symbol clock from link
   input wire sym_clk,
   // modulator outputs
   output reg tx_bit_q,
   output reg signed [12:0] freq_word_q,
   output reg pa_en_q,
   output reg [7:0] amp_q,
   output reg [2:0] msk_frac_q,
   // status
   output reg gp_output_pin_0,
   output reg gp_output_pin_2,
   output reg [7:0] status_byte_q
);
   localparam S_IDLE = 3'd0;
   localparam S_PRE = 3'd1;
   localparam S_SYNC = 3'd2;
   localparam S_DATA = 3'd3;
   localparam S_CRC = 3'd4;
   localparam S_PAD = 3'd5;
   localparam S_UFLOW = 3'd6;
   localparam S_DONE = 3'd7;
   localparam DEPTH = 1 << DEPTH_LOG2;

   function [15:0] crc16_byte;
      input [15:0] c;
      input [7:0] b;
      integer i;
      reg [15:0] t;
      begin
         t = c;
         for (i = 7; i >= 0; i = i - 1) begin
            if (t[15] ^ b[i])
               t = {t[14:0], 1'b0} ^ `TXPH_CRC_POLY;
            else
               t = {t[14:0], 1'b0};
         end
         crc16_byte = t;
      end
   endfunction

   function [8:0] pn9_adv8;
      input [8:0] p;
      integer i;
      reg [8:0] t;
      begin
         t = p;
         for (i = 0; i < 8; i = i + 1)
            t = {t[0] ^ t[5], t[8:1]};
         pn9_adv8 = t;
      end
   endfunction

   // registers
   reg [7:0] pkt_ctrl_word_q;
   reg [7:0] packet_length_reg_q;
   reg [11:0] modem_cfg_q;
   reg [15:0] sync_q;
   reg [6:0] freq_deviation_reg_q;
   reg [13:0] gp_cfg_q;
   reg [15:0] ask_cfg_q;
   wire [1:0] len_mode = pkt_ctrl_word_q[`TXPH_LEN_MODE_LSB +: 2];
   wire crc_en = pkt_ctrl_word_q[`TXPH_CRC_EN_BIT];
   wire whitening_enable = pkt_ctrl_word_q[`TXPH_WHITE_BIT];
   wire [1:0] after_tx_state_sel = pkt_ctrl_word_q[`TXPH_AFTER_LSB +: 2];
   wire [2:0] mod_fmt = modem_cfg_q[`TXPH_MOD_LSB +: 3];
   wire manch_en = modem_cfg_q[`TXPH_MANCH_BIT];
   wire error_coding_enable = modem_cfg_q[`TXPH_FEC_BIT];
   wire sync4 = modem_cfg_q[`TXPH_SYNC4_BIT];
   wire [3:0] num_pre = modem_cfg_q[`TXPH_NPRE_LSB +: 4];

   // apb decode
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire wr_fifo = wr & (paddr == `TXPH_OFF_FIFO);
   wire wr_cmd = wr & (paddr == `TXPH_OFF_CMD);
   wire tx_stb = wr_cmd & pwdata[`TXPH_CMD_TX];
   wire flush_tx_strobe = wr_cmd & pwdata[`TXPH_CMD_FLUSH];
   wire idle_stb = wr_cmd & pwdata[`TXPH_CMD_IDLE];

   // transmit fifo
   reg [7:0] mem [0:DEPTH-1];
   reg [DEPTH_LOG2-1:0] wp_q, rp_q;
   reg [DEPTH_LOG2:0] cnt_q;
   wire fifo_empty = (cnt_q == 0);
   wire fifo_full = (cnt_q == DEPTH);
   wire [7:0] fifo_head = mem[rp_q];
   reg pop;

   // symbol clock edge detect
   reg sclk_s1_q, sclk_s2_q, sclk_s3_q;
   wire sym_tick = sclk_s2_q & ~sclk_s3_q;

   // packet engine state
   reg [2:0] st_q, st_d;
   reg [7:0] bcnt_q, bcnt_d;
   reg [7:0] vlen_q, vlen_d;
   reg [3:0] preq_q, preq_d;
   reg [1:0] sidx_q, sidx_d;
   reg [15:0] crc_q, crc_d;
   reg [8:0] pn_q, pn_d;
   reg [7:0] fbuf_q, fbuf_d;
   reg fhalf_q, fhalf_d;
   reg [2:0] fst_q, fst_d;
   reg [31:0] sr_q;
   reg [5:0] left_q;
   reg ld, sync_done, pkt_end;
   reg [31:0] ld_sr;
   reg [5:0] ld_n;
   reg pkt_flag_q;

   // byte currently produced
   reg emit, coded;
   reg [7:0] eb, wb;
   reg [15:0] iw;
   integer k, r, c;

   always @* begin
      st_d = st_q;
      bcnt_d = bcnt_q;
      vlen_d = vlen_q;
      preq_d = preq_q;
      sidx_d = sidx_q;
      crc_d = crc_q;
      pn_d = pn_q;
      fbuf_d = fbuf_q;
      fhalf_d = fhalf_q;
      fst_d = fst_q;
      ld = 1'b0;
      ld_sr = 32'h0000_0000;
      ld_n = 6'd0;
      pop = 1'b0;
      sync_done = 1'b0;
      pkt_end = 1'b0;
      emit = 1'b0;
      coded = 1'b0;
      eb = 8'h00;
      wb = 8'h00;
      iw = 16'h0000;
      k = 0;
      r = 0;
      c = 0;
      if (left_q == 6'd0) begin
         case (st_q)
            S_PRE: begin
               if (preq_q >= num_pre && !fifo_empty) begin
                  st_d = S_SYNC;
                  sidx_d = 2'd0;
               end else begin
                  emit = 1'b1;
                  eb = `TXPH_PREAMBLE_BYTE;
                  if (preq_q != 4'hF)
                     preq_d = preq_q + 4'd1;
               end
            end
            S_SYNC: begin
               emit = 1'b1;
               eb = sidx_q[0] ? sync_q[7:0] : sync_q[15:8];
               sidx_d = sidx_q + 2'd1;
               if (sidx_q == (sync4 ? 2'd3 : 2'd1)) begin
                  st_d = S_DATA;
                  sync_done = 1'b1;
                  pn_d = `TXPH_PN9_SEED;
                  crc_d = `TXPH_CRC_SEED;
                  bcnt_d = 8'h00;
                  fhalf_d = 1'b0;
                  fst_d = 3'd0;
               end
            end
            S_DATA: begin
               if (fifo_empty) begin
                  st_d = S_UFLOW;
               end else begin
                  emit = 1'b1;
                  coded = 1'b1;
                  eb = fifo_head;
                  pop = 1'b1;
                  crc_d = crc16_byte(crc_q, fifo_head);
                  bcnt_d = bcnt_q + 8'd1;
                  if (len_mode == `TXPH_LEN_VAR && bcnt_q == 8'h00)
                     vlen_d = fifo_head;
                  // mode is read live so it may change mid-packet
                  if ((len_mode == `TXPH_LEN_FIXED &&
                       bcnt_d == packet_length_reg_q) ||
                      (len_mode == `TXPH_LEN_VAR && bcnt_q != 8'h00 &&
                       bcnt_q == vlen_q)) begin
                     sidx_d = 2'd0;
                     if (crc_en)
                        st_d = S_CRC;
                     else if (error_coding_enable)
                        st_d = S_PAD;
                     else
                        pkt_end = 1'b1;
                  end
               end
            end
            S_CRC: begin
               emit = 1'b1;
               coded = 1'b1;
               eb = sidx_q[0] ? crc_q[7:0] : crc_q[15:8];
               sidx_d = sidx_q + 2'd1;
               if (sidx_q[0]) begin
                  if (error_coding_enable)
                     st_d = S_PAD;
                  else
                     pkt_end = 1'b1;
               end
            end
            S_PAD: begin
               // one pad when odd, two when even, for trellis end
               emit = 1'b1;
               coded = 1'b1;
               eb = `TXPH_FEC_PAD;
               if (fhalf_q)
                  pkt_end = 1'b1;
            end
            S_DONE: begin
               // keep the last symbol on air until its tick ends it
               if (sym_tick) begin
                  st_d = (after_tx_state_sel == 2'd2) ? S_PRE :
                     S_IDLE;
                  preq_d = 4'd0;
               end
            end
            default: ;
         endcase
      end
      if (pkt_end)
         st_d = S_DONE;
      if (emit) begin
         wb = eb;
         if (coded && whitening_enable) begin
            wb = eb ^ pn_q[7:0];
            pn_d = pn9_adv8(pn_q);
         end
         if (coded && error_coding_enable) begin
            if (!fhalf_q) begin
               fbuf_d = wb;
               fhalf_d = 1'b1;
            end else begin
               // rows written, columns read, then rate 1/2 code
               fhalf_d = 1'b0;
               iw = {fbuf_q, wb};
               fst_d = fst_q;
               for (c = 0; c < 4; c = c + 1)
                  for (r = 0; r < 4; r = r + 1) begin
                     k = c * 4 + r;
                     ld_sr[31 - 2 * k] = iw[15 - (r * 4 + c)] ^
                        fst_d[2] ^ fst_d[1] ^ fst_d[0];
                     ld_sr[30 - 2 * k] = iw[15 - (r * 4 + c)] ^
                        fst_d[1] ^ fst_d[0];
                     fst_d = {fst_d[1:0], iw[15 - (r * 4 + c)]};
                  end
               ld = 1'b1;
               ld_n = 6'd32;
            end
         end else if (manch_en) begin
            for (k = 0; k < 8; k = k + 1) begin
               ld_sr[31 - 2 * k] = wb[7 - k];
               ld_sr[30 - 2 * k] = ~wb[7 - k];
            end
            ld = 1'b1;
            ld_n = 6'd16;
         end else begin
            ld_sr = {wb, 24'h000000};
            ld = 1'b1;
            ld_n = 6'd8;
         end
      end
      if (tx_stb && st_q == S_IDLE) begin
         st_d = S_PRE;
         preq_d = 4'd0;
      end
      if (idle_stb && st_q != S_UFLOW)
         st_d = S_IDLE;
      if (flush_tx_strobe && (st_q == S_UFLOW || st_q == S_IDLE))
         st_d = S_IDLE;
   end

   // symbol mapping targets
   wire [10:0] dev_mag = {7'd0, 1'b1, freq_deviation_reg_q[2:0]} <<
      freq_deviation_reg_q[6:4];
   wire msk = (mod_fmt == `TXPH_MOD_MSK);
   wire sym_pos = msk ? ~tx_bit_q : tx_bit_q;
   wire am = (mod_fmt == `TXPH_MOD_OOK) || (mod_fmt == `TXPH_MOD_ASK);
   wire signed [12:0] f_tgt = (am || st_q == S_IDLE) ? 13'sd0 :
      (sym_pos ? $signed({2'b00, dev_mag}) :
      -$signed({2'b00, dev_mag}));
   wire signed [12:0] f_err = f_tgt - freq_word_q;
   wire [7:0] a_tgt = (mod_fmt == `TXPH_MOD_OOK) ?
      (tx_bit_q ? 8'hFF : 8'h00) :
      (tx_bit_q ? 8'hFF : 8'hFF - ask_cfg_q[7:0]);

   always @(posedge clk) begin
      if (srst) begin
         pkt_ctrl_word_q <= `TXPH_RST_PKT_CTRL;
         packet_length_reg_q <= `TXPH_RST_PKT_LEN;
         modem_cfg_q <= `TXPH_RST_MODEM;
         sync_q <= `TXPH_RST_SYNC;
         freq_deviation_reg_q <= `TXPH_RST_DEV;
         gp_cfg_q <= `TXPH_RST_GP_CFG;
         ask_cfg_q <= `TXPH_RST_ASK;
         wp_q <= {DEPTH_LOG2{1'b0}};
         rp_q <= {DEPTH_LOG2{1'b0}};
         cnt_q <= {(DEPTH_LOG2+1){1'b0}};
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         st_q <= S_IDLE;
         bcnt_q <= 8'h00;
         vlen_q <= 8'h00;
         preq_q <= 4'd0;
         sidx_q <= 2'd0;
         crc_q <= `TXPH_CRC_SEED;
         pn_q <= `TXPH_PN9_SEED;
         fbuf_q <= 8'h00;
         fhalf_q <= 1'b0;
         fst_q <= 3'd0;
         sr_q <= 32'h0000_0000;
         left_q <= 6'd0;
         pkt_flag_q <= 1'b0;
         tx_bit_q <= 1'b0;
         freq_word_q <= 13'sd0;
         pa_en_q <= 1'b0;
         amp_q <= 8'h00;
         msk_frac_q <= 3'd0;
         gp_output_pin_0 <= 1'b0;
         gp_output_pin_2 <= 1'b0;
         status_byte_q <= 8'h00;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         sclk_s1_q <= sym_clk;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         // register writes
         if (wr) begin
            case (paddr)
               `TXPH_OFF_PKT_CTRL: pkt_ctrl_word_q <= pwdata[7:0];
               `TXPH_OFF_PKT_LEN: packet_length_reg_q <= pwdata[7:0];
               `TXPH_OFF_MODEM: modem_cfg_q <= pwdata[11:0];
               `TXPH_OFF_SYNC: sync_q <= pwdata[15:0];
               `TXPH_OFF_DEV: freq_deviation_reg_q <= pwdata[6:0];
               `TXPH_OFF_GP_CFG: gp_cfg_q <= pwdata[13:0];
               `TXPH_OFF_ASK: ask_cfg_q <= pwdata[15:0];
               default: ;
            endcase
         end
         // fifo; flush empties it only when not sending
         if (flush_tx_strobe && (st_q == S_UFLOW || st_q == S_IDLE)) begin
            wp_q <= {DEPTH_LOG2{1'b0}};
            rp_q <= {DEPTH_LOG2{1'b0}};
            cnt_q <= {(DEPTH_LOG2+1){1'b0}};
         end else begin
            if (wr_fifo && !fifo_full) begin
               mem[wp_q] <= pwdata[7:0];
               wp_q <= wp_q + 1'b1;
            end
            if (pop)
               rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + {{DEPTH_LOG2{1'b0}}, (wr_fifo & ~fifo_full)}
               - {{DEPTH_LOG2{1'b0}}, pop};
         end
         // packet engine
         st_q <= st_d;
         bcnt_q <= bcnt_d;
         vlen_q <= vlen_d;
         preq_q <= preq_d;
         sidx_q <= sidx_d;
         crc_q <= crc_d;
         pn_q <= pn_d;
         fbuf_q <= fbuf_d;
         fhalf_q <= fhalf_d;
         fst_q <= fst_d;
         if (st_d == S_IDLE || st_d == S_UFLOW) begin
            left_q <= 6'd0;
         end else if (ld) begin
            sr_q <= ld_sr;
            left_q <= ld_n;
         end else if (sym_tick && left_q != 6'd0) begin
            tx_bit_q <= sr_q[31];
            sr_q <= {sr_q[30:0], 1'b0};
            left_q <= left_q - 6'd1;
         end
         if (sync_done)
            pkt_flag_q <= 1'b1;
         else if ((st_q == S_DONE && st_d != S_DONE) ||
            st_q == S_IDLE || st_q == S_UFLOW)
            pkt_flag_q <= 1'b0;
         // modulator
         if (mod_fmt == `TXPH_MOD_GFSK)
            freq_word_q <= freq_word_q + (f_err >>> 3);
         else if (msk)
            freq_word_q <= freq_word_q +
               (f_err >>> (3'd1 + {1'b0, freq_deviation_reg_q[1:0]}));
         else
            freq_word_q <= f_tgt;
         pa_en_q <= (st_q != S_IDLE && st_q != S_UFLOW) &&
            ((mod_fmt != `TXPH_MOD_OOK) || tx_bit_q);
         if (st_q == S_IDLE || st_q == S_UFLOW)
            amp_q <= 8'h00;
         else if (mod_fmt != `TXPH_MOD_ASK || ask_cfg_q[15:8] == 8'h00)
            amp_q <= am ? a_tgt : 8'hFF;
         else if (amp_q < a_tgt)
            amp_q <= (8'hFF - amp_q < ask_cfg_q[15:8]) ? a_tgt :
               ((amp_q + ask_cfg_q[15:8] > a_tgt) ? a_tgt :
               amp_q + ask_cfg_q[15:8]);
         else if (amp_q > a_tgt)
            amp_q <= (amp_q - a_tgt < ask_cfg_q[15:8]) ? a_tgt :
               amp_q - ask_cfg_q[15:8];
         msk_frac_q <= msk ? freq_deviation_reg_q[2:0] : 3'd0;
         gp_output_pin_0 <= gp_sel(gp_cfg_q[5:0]);
         gp_output_pin_2 <= gp_sel(gp_cfg_q[13:8]);
         // apb answer, one wait-free access phase
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            pslverr <= (paddr > `TXPH_OFF_ASK) || (paddr[1:0] != 2'b00);
            case (paddr)
               `TXPH_OFF_PKT_CTRL: prdata <= {24'h0, pkt_ctrl_word_q};
               `TXPH_OFF_PKT_LEN: prdata <= {24'h0, packet_length_reg_q};
               `TXPH_OFF_MODEM: prdata <= {20'h0, modem_cfg_q};
               `TXPH_OFF_SYNC: prdata <= {16'h0, sync_q};
               `TXPH_OFF_DEV: prdata <= {25'h0, freq_deviation_reg_q};
               `TXPH_OFF_GP_CFG: prdata <= {18'h0, gp_cfg_q};
               `TXPH_OFF_FILL: prdata <= {25'h0, fifo_full,
                  cnt_q[DEPTH_LOG2-1:0]};
               `TXPH_OFF_PKT_STAT: prdata <= {27'h0, gp_output_pin_2,
                  3'b000, gp_output_pin_0};
               `TXPH_OFF_ASK: prdata <= {16'h0, ask_cfg_q};
               default: prdata <= 32'h0000_0000;
            endcase
            status_byte_q <= {1'b0, st_q,
               (cnt_q > 15) ? 4'hF : cnt_q[3:0]};
         end
      end
   end

   function gp_sel;
      input [5:0] s;
      begin
         case (s)
            `TXPH_GP_FIFO_THR: gp_sel = (cnt_q >= FIFO_THR);
            `TXPH_GP_FIFO_FULL: gp_sel = fifo_full;
            `TXPH_GP_SYNC_PKT: gp_sel = pkt_flag_q;
            default: gp_sel = 1'b0;
         endcase
      end
   endfunction
endmodule
`default_nettype wire

// file: txph_consts.vh
// constants for the transmit packet handler and symbol mapper
`ifndef TXPH_CONSTS_VH
`define TXPH_CONSTS_VH

// register byte offsets
`define TXPH_OFF_PKT_CTRL   8'h00
`define TXPH_OFF_PKT_LEN    8'h04
`define TXPH_OFF_MODEM      8'h08
`define TXPH_OFF_SYNC       8'h0C
`define TXPH_OFF_DEV        8'h10
`define TXPH_OFF_GP_CFG     8'h14
`define TXPH_OFF_FIFO       8'h18
`define TXPH_OFF_CMD        8'h1C
`define TXPH_OFF_FILL       8'h20
`define TXPH_OFF_PKT_STAT   8'h24
`define TXPH_OFF_ASK        8'h28

// packet_ctrl_word fields
`define TXPH_LEN_MODE_LSB   0
`define TXPH_CRC_EN_BIT     2
`define TXPH_WHITE_BIT      3
`define TXPH_AFTER_LSB      4
// modem_config fields
`define TXPH_MOD_LSB        0
`define TXPH_MANCH_BIT      3
`define TXPH_FEC_BIT        4
`define TXPH_SYNC4_BIT      5
`define TXPH_NPRE_LSB       8
// command strobe bits
`define TXPH_CMD_TX         0
`define TXPH_CMD_FLUSH      1
`define TXPH_CMD_IDLE       2

// length modes
`define TXPH_LEN_FIXED      2'h0
`define TXPH_LEN_VAR        2'h1
`define TXPH_LEN_INF        2'h2
// modulation formats
`define TXPH_MOD_FSK        3'h0
`define TXPH_MOD_GFSK       3'h1
`define TXPH_MOD_OOK        3'h2
`define TXPH_MOD_ASK        3'h3
`define TXPH_MOD_MSK        3'h4
// gp output selects
`define TXPH_GP_FIFO_THR    6'h02
`define TXPH_GP_FIFO_FULL   6'h03
`define TXPH_GP_SYNC_PKT    6'h06

// reset values
`define TXPH_RST_PKT_CTRL   8'h00
`define TXPH_RST_PKT_LEN    8'hFF
`define TXPH_RST_MODEM      12'h400
`define TXPH_RST_SYNC       16'hD391
`define TXPH_RST_DEV        7'h47
`define TXPH_RST_GP_CFG     14'h0606
`define TXPH_RST_ASK        16'h0840

// data values
`define TXPH_PREAMBLE_BYTE  8'h55
`define TXPH_PN9_SEED       9'h1FF
`define TXPH_CRC_SEED       16'hFFFF
`define TXPH_CRC_POLY       16'h8005
`define TXPH_FEC_PAD        8'h00

// symbol clock period in the bench, ns
`define TXPH_SYM_CLK_NS     200

`endif

// file: txph_checker.sv
// port assertions for the transmit packet handler
`timescale 1ns/1ps
`default_nettype none
module txph_checker (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // link and status
   input wire logic sym_clk,
   input wire logic tx_bit_q,
   input wire logic gp_output_pin_0,
   input wire logic gp_output_pin_2,
   input wire logic [7:0] status_byte_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   logic [3:0] age_q;
   logic sym_q;
   logic setup_q;
   // cycles since the last symbol clock rise
   always @(posedge clk) begin
      sym_q <= srst ? 1'b0 : sym_clk;
      setup_q <= srst ? 1'b0 : (psel && !penable);
      if (srst || (sym_clk && !sym_q)) begin
         age_q <= 4'h0;
      end else if (age_q != 4'hF) begin
         age_q <= age_q + 4'h1;
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_rd(logic [7:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> pready)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_err_unmapped: assert property (s_setup ##0
      (paddr > 8'h28 || paddr[1:0] != 2'h0) |=> pslverr)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (s_setup ##0
      (paddr <= 8'h28 && paddr[1:0] == 2'h0) |=> !pslverr)
      else $error("mapped access refused");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside access phase");
   a_upper_zero: assert property (pready && !pwrite && !pslverr
      |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   a_status_on_setup: assert property ($changed(status_byte_q) |-> setup_q)
      else $error("status byte changed outside setup");
   a_pin_status: assert property (s_rd(8'h24) |=>
      prdata[0] == $past(gp_output_pin_0) && prdata[4] == $past(gp_output_pin_2))
      else $error("packet status differs from pins");
   a_fill_status: assert property (s_rd(8'h20) |=>
      status_byte_q[3:0] == (prdata[6:0] > 7'h0F ? 4'hF : prdata[3:0]))
      else $error("status fill count differs");
   a_bit_on_symbol: assert property ($rose(tx_bit_q) |-> age_q inside {[1:7]})
      else $error("symbol changed without a link tick");
endmodule
`default_nettype wire

// file: txph_link_src.sv
// symbol clock source of the link side, still while not running
`timescale 1ns/1ps
`default_nettype none
module txph_link_src (
   // control
   input wire logic run,
   // link clock
   output logic sym_clk
);
   initial begin
      sym_clk = 1'b0;
      #37;
      forever begin
         #100;
         sym_clk = run ? ~sym_clk : 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: tx_packet_handler_modulator_test.sv
// self-checking bench for the transmit packet handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tx_packet_handler_modulator_test;
   logic clk, srst, psel, penable, pwrite, sym_clk, run, pa_en_q, pin0, pin2;
   logic pready, pslverr, tx_bit_q;
   logic [7:0] paddr, sh, amp_q, status_byte_q;
   logic [31:0] pwdata, prdata;
   logic signed [12:0] freq_word_q;
   logic [2:0] msk_frac_q, fmt;
   logic [32:0] e;
   logic [8:0] e2;
   logic [32:0] rq[$];
   logic [8:0] bq[$];
   logic [7:0] ra[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h28,
      8'h2C, 8'h02};
   logic [32:0] rv[9] = '{33'h0, 33'hFF, 33'h400, 33'hD391, 33'h47, 33'h606,
      33'h840, 33'h100000000, 33'h100000000};
   int fail_count, n_checks, nb;
   txph_top uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sym_clk(sym_clk),
      .tx_bit_q(tx_bit_q), .freq_word_q(freq_word_q), .pa_en_q(pa_en_q),
      .amp_q(amp_q), .msk_frac_q(msk_frac_q), .gp_output_pin_0(pin0),
      .gp_output_pin_2(pin2), .status_byte_q(status_byte_q));
   txph_link_src link (.run(run), .sym_clk(sym_clk));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n == 20) fail_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] x);
      rq.push_back(x);
      apb(1'b0, a, 32'h0);
   endtask
   // read results against noted expectations
   always @(posedge clk) begin
      if (pready === 1'b1 && pwrite === 1'b0 && rq.size() > 0) begin
         e = rq.pop_front();
         `CHK(pslverr, e[32])
         if (!e[32]) `CHK(prdata, e[31:0])
      end
   end
   // symbol stream against noted bytes, sampled mid-symbol
   always @(posedge sym_clk) begin
      repeat (6) @(posedge clk);
      if (bq.size() > 0) begin
         sh = {sh[6:0], tx_bit_q};
         nb++;
         if (bq[0][8] && nb == 1) `CHK(pin0, 1'b1)
         if (fmt == 3'h0) `CHK(freq_word_q, tx_bit_q ? 13'h00F0 : 13'h1F10)
         if (fmt == 3'h2) `CHK(pa_en_q, tx_bit_q)
         if (fmt == 3'h2) `CHK(amp_q, tx_bit_q ? 8'hFF : 8'h00)
         if (fmt[1]) `CHK(freq_word_q, 13'h0000)
         if (fmt == 3'h4) `CHK(msk_frac_q, 3'h7)
         if (nb == 8) begin
            e2 = bq.pop_front();
            `CHK(sh, e2[7:0])
            nb = 0;
         end
      end
   end
   task automatic pkt(input logic [2:0] f, input logic [7:0] c, input int n);
      logic [7:0] b;
      logic [15:0] crc;
      fmt = f;
      crc = 16'hFFFF;
      apb(1'b1, 8'h08, 32'h400 | f);
      apb(1'b1, 8'h00, c);
      apb(1'b1, 8'h04, n);
      for (int i = 0; i < 4; i++) bq.push_back(9'h055);
      bq.push_back(9'h0D3);
      bq.push_back(9'h091);
      for (int i = 0; i < n; i++) begin
         b = (c[0] && i == 0) ? 8'(n - 1) : 8'($urandom);
         apb(1'b1, 8'h18, b);
         bq.push_back({1'b1, b});
         for (int k = 7; k >= 0; k--)
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[k]) ? 16'h8005 : 16'h0);
      end
      if (c[2]) bq.push_back({1'b0, crc[15:8]});
      if (c[2]) bq.push_back({1'b0, crc[7:0]});
      rd(8'h20, n);
      nb = 0;
      apb(1'b1, 8'h1C, 32'h1);
      run = 1'b1;
      if (c[1]) apb(1'b1, 8'h00, c & 8'hFC);
      for (int t = 0; t < 4000 && bq.size() > 0; t++) @(posedge clk);
      `CHK(bq.size(), 0)
      repeat (200) @(posedge clk);
      run = 1'b0;
      rd(8'h20, 0);
      `CHK(status_byte_q[6:4], 3'h0)
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, run, fmt, sh} = '0;
      srst = 1'b1;
      void'($urandom(34));
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      foreach (ra[i]) rd(ra[i], rv[i]);
      apb(1'b1, 8'h30, 32'h0);
      $display("test registers done");
      pkt(3'h0, 8'h04, 3);
      pkt(3'h2, 8'h01, 3);
      pkt(3'h3, 8'h00, 2);
      pkt(3'h4, 8'h00, 2);
      pkt(3'h1, 8'h04, 2);
      pkt(3'h0, 8'h06, 3);
      $display("test packets done");
      apb(1'b1, 8'h04, 32'h4);
      apb(1'b1, 8'h18, 32'hA5);
      apb(1'b1, 8'h1C, 32'h1);
      run = 1'b1;
      repeat (1500) @(posedge clk);
      rd(8'h20, 0);
      `CHK(status_byte_q[6:4], 3'h6)
      apb(1'b1, 8'h18, 32'h5A);
      repeat (100) @(posedge clk);
      rd(8'h20, 1);
      `CHK(status_byte_q[6:4], 3'h6)
      apb(1'b1, 8'h1C, 32'h2);
      rd(8'h20, 0);
      `CHK(status_byte_q[6:4], 3'h0)
      run = 1'b0;
      $display("test underflow done");
      apb(1'b1, 8'h14, 32'h0206);
      for (int i = 0; i < 32; i++) apb(1'b1, 8'h18, i);
      rd(8'h24, 0);
      apb(1'b1, 8'h18, 32'h20);
      rd(8'h24, 32'h10);
      apb(1'b1, 8'h1C, 32'h2);
      $display("test fill level done");
      stop_test();
   end
   initial begin
      #2000000;
      fail_count++;
      stop_test();
   end
endmodule
bind txph_top txph_checker chk (.clk(clk), .srst(srst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sym_clk(sym_clk),
   .tx_bit_q(tx_bit_q), .gp_output_pin_0(gp_output_pin_0),
   .gp_output_pin_2(gp_output_pin_2), .status_byte_q(status_byte_q));
`default_nettype wire
